// File: core/dssp_slave.sv
/*
  Slave end of the debug serial port: takes a command byte, a 16-bit
  address and 16-bit data words from the master and turns them into word
  writes and reads on a simple memory port, with address auto-increment.
  Assumes the link wires arrive from another clock domain and that the
  memory answers a read one cycle after the read strobe.
*/
`default_nettype none
// Notes on behaviour
// (RQ1) select high two clocks resets the port
// (RQ2) master drops select, sends command byte
// (RQ3) sixteen-bit address follows the command
// (RQ4) data moves in sixteen-bit words
// (RQ5) select stays low through a transaction
// (RQ6) data in sampled on clock rise
// (RQ7) data out changes on clock fall
// (RQ8) only the master drives the clock
// (RQ9) select high ends transfer, drops partial word
// (RQ10) each further sixteen clocks moves next word
// (RQ11) command 02 hex selects a write
// (RQ12) write words stored at incrementing addresses
// (RQ13) command 03 hex selects a read
// (RQ14) read returns check word, then data
// (RQ15) check word is command and address high
// (RQ16) read continues at next address per word
// (RQ17) deselected output: 0 running, 1 stopped
// (RQ18) no parallel wiring with other slaves
// (RQ19) every field most significant bit first
// (RQ20) unknown command: no access, ignore rest
module dssp_slave (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // serial link
  dssp_link_if.slave       link,
  // processor status
  input  wire logic        cpu_stopped,
  // memory port
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic             mem_wr,
  output logic             mem_rd,
  input  wire logic [15:0] mem_rdata,
  // status
  output logic             sel_active,
  output logic             cmd_bad
);

  typedef struct packed {
    dssp_pkg::dssp_sst_t st;
    logic                armed;
    logic [1:0]          rst_cnt;
    logic [2:0]          cs_sy;
    logic [2:0]          ck_sy;
    logic [2:0]          di_sy;
    logic                cs_f;
    logic                ck_f;
    logic                di_f;
    logic [4:0]          cnt;
    logic [15:0]         sh;
    logic [7:0]          cmd;
    logic [15:0]         addr;
    logic [15:0]         tx;
    logic [3:0]          ocnt;
    logic [15:0]         rd_buf;
    logic                rd_pend;
    logic                miso;
    logic [15:0]         mem_addr;
    logic [15:0]         mem_wdata;
    logic                mem_wr;
    logic                mem_rd;
    logic                sel_active;
    logic                cmd_bad;
  } dssp_slv_t;

  dssp_slv_t s;
  dssp_slv_t next_s;

  // a change counts only once the second and third stages agree
  function automatic logic settle(input logic [2:0] sy, input logic f);
    settle = (sy[1] == sy[2]) ? sy[2] : f;
  endfunction

  logic        cs_n;
  logic        ck_n;
  logic        rise;
  logic        fall;
  logic [15:0] sh_n;

  // next state of the whole port
  always_comb begin
    next_s        = s;
    next_s.mem_wr = 1'b0;
    next_s.mem_rd = 1'b0;
    next_s.cmd_bad = 1'b0;
    // the serial clock is only ever an input here
    next_s.cs_sy = {s.cs_sy[1:0], link.cs_b}; // RQ8
    next_s.ck_sy = {s.ck_sy[1:0], link.sclk};
    next_s.di_sy = {s.di_sy[1:0], link.mosi};
    cs_n  = settle(s.cs_sy, s.cs_f);
    ck_n  = settle(s.ck_sy, s.ck_f);
    next_s.cs_f = cs_n;
    next_s.ck_f = ck_n;
    next_s.di_f = settle(s.di_sy, s.di_f);
    rise  = ck_n & ~s.ck_f;
    fall  = ~ck_n & s.ck_f;
    // incoming bits enter at the bottom, so the first is the top bit
    sh_n  = {s.sh[14:0], s.di_f}; // RQ19

    // memory answers one cycle after the read strobe
    next_s.rd_pend = s.mem_rd;
    if (s.rd_pend) begin
      next_s.rd_buf = mem_rdata;
    end

    if (cs_n) begin
      // deselected: drop any partial word and drive the status level
      next_s.st         = dssp_pkg::S_IDLE; // RQ9
      next_s.cnt        = 5'd0;
      next_s.sel_active = 1'b0;
      next_s.miso       = cpu_stopped; // RQ17
      if (rise && s.rst_cnt != 2'(dssp_pkg::RST_CLKS)) begin
        next_s.rst_cnt = s.rst_cnt + 2'd1; // RQ1
      end
      if (rise && s.rst_cnt == 2'(dssp_pkg::RST_CLKS - 1)) begin
        next_s.armed = 1'b1; // RQ1
      end
    end else if (s.cs_f) begin
      // select just fell: a port never re-armed ignores the frame
      next_s.rst_cnt    = 2'd0;
      next_s.cnt        = 5'd0;
      next_s.sel_active = 1'b1;
      next_s.miso       = dssp_pkg::MISO_SEL_IDLE;
      next_s.st = s.armed ? dssp_pkg::S_CMD : dssp_pkg::S_IGNORE; // RQ2
    end else begin
      case (s.st)
        dssp_pkg::S_CMD: begin
          if (rise) begin
            next_s.sh  = sh_n; // RQ6
            next_s.cnt = s.cnt + 5'd1;
            if (s.cnt == 5'(dssp_pkg::CMD_BITS - 1)) begin
              next_s.cmd = sh_n[7:0]; // RQ2
              next_s.cnt = 5'd0;
              next_s.st  = dssp_pkg::S_ADDR;
            end
          end
        end
        dssp_pkg::S_ADDR: begin
          if (rise) begin
            next_s.sh  = sh_n;
            next_s.cnt = s.cnt + 5'd1;
            if (s.cnt == 5'(dssp_pkg::ADDR_BITS - 1)) begin
              next_s.cnt = 5'd0;
              if (s.cmd == dssp_pkg::CMD_WRITE) begin
                next_s.addr = sh_n; // RQ3
                next_s.st   = dssp_pkg::S_WDATA; // RQ11
              end else if (s.cmd == dssp_pkg::CMD_READ) begin
                // fetch the first word while the check word goes out
                next_s.tx       = {s.cmd, sh_n[15:8]}; // RQ15
                next_s.ocnt     = 4'd0;
                next_s.mem_addr = sh_n; // RQ13
                next_s.mem_rd   = 1'b1;
                next_s.addr     = sh_n + 16'h0001;
                next_s.st       = dssp_pkg::S_RDATA; // RQ14
              end else begin
                next_s.cmd_bad = 1'b1;
                next_s.st      = dssp_pkg::S_IGNORE; // RQ20
              end
            end
          end
        end
        dssp_pkg::S_WDATA: begin
          // each full word is written, then the address steps on
          if (rise) begin
            next_s.sh  = sh_n;
            next_s.cnt = s.cnt + 5'd1;
            if (s.cnt == 5'(dssp_pkg::WORD_BITS - 1)) begin
              next_s.cnt       = 5'd0;
              next_s.mem_addr  = s.addr; // RQ12
              next_s.mem_wdata = sh_n; // RQ4
              next_s.mem_wr    = 1'b1;
              next_s.addr      = s.addr + 16'h0001; // RQ10
            end
          end
        end
        dssp_pkg::S_RDATA: begin
          // one bit leaves per fall; the last bit of a word loads the
          // next one and starts the fetch after it, so the memory has
          // sixteen serial clocks to answer
          if (fall) begin
            next_s.miso = s.tx[15]; // RQ7
            next_s.ocnt = s.ocnt + 4'd1;
            if (s.ocnt == 4'(dssp_pkg::WORD_BITS - 1)) begin
              next_s.tx       = s.rd_buf; // RQ14
              next_s.mem_addr = s.addr; // RQ16
              next_s.mem_rd   = 1'b1;
              next_s.addr     = s.addr + 16'h0001; // RQ10
            end else begin
              next_s.tx = {s.tx[14:0], 1'b0}; // RQ19
            end
          end
        end
        default: begin
          // idle or ignoring: wait for select to rise
          next_s.cnt = 5'd0;
        end
      endcase
    end
  end

  // one register for the whole port; link wires start at their idle level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s         <= '0;
      s.st      <= dssp_pkg::S_IDLE;
      s.cs_sy   <= 3'b111;
      s.cs_f    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // every output straight from the register
  assign link.miso  = s.miso; // RQ17
  assign mem_addr   = s.mem_addr;
  assign mem_wdata  = s.mem_wdata;
  assign mem_wr     = s.mem_wr;
  assign mem_rd     = s.mem_rd;
  assign sel_active = s.sel_active;
  assign cmd_bad    = s.cmd_bad;

endmodule
`default_nettype wire

// File: core/dssp_pkg.sv
/*
  Shared constants and types for the debug serial port: the command codes,
  the frame field widths, the serial clock timing and the state sets of
  both ends.
  Assumes one 50 MHz system clock at each end. The serial clock is made
  by the master from that clock.
*/
`default_nettype none
package dssp_pkg;
  // system clock period and the serial clock period the master makes
  localparam int SYS_PERIOD_NS  = 20;
  localparam int SCLK_PERIOD_NS = 320;
  // system cycles in one half period of the serial clock
  localparam int HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);

  // serial clock periods with select high that re-arm the port
  localparam int RST_CLKS = 2;

  // frame field widths
  localparam int CMD_BITS  = 8;
  localparam int ADDR_BITS = 16;
  localparam int WORD_BITS = 16;

  // command codes
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ  = 8'h03;

  // value the slave holds on its data out while selected and not reading
  localparam logic MISO_SEL_IDLE = 1'b0;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CMD,
    S_ADDR,
    S_WDATA,
    S_RDATA,
    S_IGNORE
  } dssp_sst_t;

  typedef enum logic [1:0] {
    M_IDLE,
    M_RST,
    M_HDR,
    M_WORD
  } dssp_mst_t;
endpackage
`default_nettype wire

// File: core/dssp_link_if.sv
/*
  The four wires of the debug serial link between master and slave.
  Assumes both ends are joined by the bench; no clocking block, the ends
  sample the wires with their own clocks.
*/
`default_nettype none
interface dssp_link_if;
  logic cs_b;
  logic sclk;
  logic mosi;
  logic miso;

  modport master (
    output cs_b,
    output sclk,
    output mosi,
    input  miso
  );

  modport slave (
    input  cs_b,
    input  sclk,
    input  mosi,
    output miso
  );
endinterface
`default_nettype wire

// File: core/dssp_master.sv
/*
  Master end of the debug serial port: on a start request it re-arms the
  slave, sends command and address, then writes or reads a run of words.
  Assumes the slave sits on the other end of the link interface and that
  the user holds each write word until it is taken.
*/
`default_nettype none
module dssp_master (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // serial link
  dssp_link_if.master      link,
  // request
  input  wire logic        start,
  input  wire logic [7:0]  cmd,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  nwords,
  input  wire logic [15:0] wdata,
  // answer
  output logic             busy,
  output logic             wdata_take,
  output logic      [15:0] rdata,
  output logic             rdata_valid,
  output logic      [15:0] check_word,
  output logic             check_valid
);

  typedef struct packed {
    dssp_pkg::dssp_mst_t st;
    logic [3:0]          div;
    logic [1:0]          tcnt;
    logic                cs_b;
    logic                sclk;
    logic                mosi;
    logic [4:0]          bcnt;
    logic [23:0]         tx;
    logic [15:0]         rx;
    logic                rd;
    logic                got_chk;
    logic [7:0]          left;
    logic [2:0]          mi_sy;
    logic                mi_f;
    logic                busy;
    logic                wdata_take;
    logic [15:0]         rdata;
    logic                rdata_valid;
    logic [15:0]         check_word;
    logic                check_valid;
  } dssp_mstr_t;

  dssp_mstr_t m;
  dssp_mstr_t next_m;
  logic       tick;
  logic       fin;
  logic [15:0] rx_n;

  // next state of the master
  always_comb begin
    next_m             = m;
    next_m.wdata_take  = 1'b0;
    next_m.rdata_valid = 1'b0;
    next_m.check_valid = 1'b0;
    fin                = 1'b0;
    next_m.mi_sy = {m.mi_sy[1:0], link.miso};
    next_m.mi_f  = (m.mi_sy[1] == m.mi_sy[2]) ? m.mi_sy[2] : m.mi_f;
    rx_n  = {m.rx[14:0], m.mi_f};
    // divider: one tick per half serial clock
    tick = (m.div == 4'(dssp_pkg::HALF_CYC - 1));
    next_m.div = tick ? 4'd0 : m.div + 4'd1;
    case (m.st)
      dssp_pkg::M_IDLE: begin
        next_m.div = 4'd0;
        if (start) begin
          next_m.tx   = {cmd, addr};
          next_m.rd   = (cmd == dssp_pkg::CMD_READ);
          next_m.left = (nwords == 8'h00) ? 8'h01 : nwords;
          next_m.got_chk = 1'b0;
          next_m.tcnt = 2'd0;
          next_m.busy = 1'b1;
          next_m.st   = dssp_pkg::M_RST;
        end
      end
      dssp_pkg::M_RST: begin
        // two clock periods with select high, then select low
        if (tick) begin
          next_m.sclk = ~m.sclk; // RQ8
          next_m.tcnt = m.tcnt + 2'd1; // RQ1
          if (m.tcnt == 2'(2 * dssp_pkg::RST_CLKS - 1)) begin
            next_m.cs_b = 1'b0; // RQ2
            next_m.mosi = m.tx[23];
            next_m.bcnt = 5'd0;
            next_m.st   = dssp_pkg::M_HDR;
          end
        end
      end
      default: begin
        if (tick && !m.sclk) begin
          next_m.sclk = 1'b1;
        end else if (tick) begin
          // sample late in the high phase: the slave answer comes back
          // through its own and our synchronisers
          next_m.rx   = rx_n;
          next_m.sclk = 1'b0;
          next_m.bcnt = m.bcnt + 5'd1;
          next_m.tx   = {m.tx[22:0], 1'b0}; // RQ19
          next_m.mosi = m.tx[22];
          if (m.st == dssp_pkg::M_HDR && m.bcnt ==
              5'(dssp_pkg::CMD_BITS + dssp_pkg::ADDR_BITS - 1)) begin
            next_m.bcnt = 5'd0;
            next_m.st   = dssp_pkg::M_WORD;
            if (!m.rd) begin
              next_m.tx         = {wdata, 8'h00};
              next_m.mosi       = wdata[15];
              next_m.wdata_take = 1'b1;
              next_m.left       = m.left - 8'h01;
            end else begin
              next_m.mosi = 1'b0;
            end
          end else if (m.st == dssp_pkg::M_WORD &&
                       m.bcnt == 5'(dssp_pkg::WORD_BITS - 1)) begin
            next_m.bcnt = 5'd0;
            if (m.rd && !m.got_chk) begin
              next_m.check_word  = rx_n; // RQ14
              next_m.check_valid = 1'b1;
              next_m.got_chk     = 1'b1;
            end else if (m.rd) begin
              next_m.rdata       = rx_n;
              next_m.rdata_valid = 1'b1;
              next_m.left        = m.left - 8'h01;
              fin                = (m.left == 8'h01);
            end else if (m.left == 8'h00) begin
              fin = 1'b1;
            end else begin
              next_m.tx         = {wdata, 8'h00};
              next_m.mosi       = wdata[15];
              next_m.wdata_take = 1'b1;
              next_m.left       = m.left - 8'h01;
            end
            if (m.rd) begin
              next_m.mosi = 1'b0;
            end
          end
        end
        // raising select ends the transaction
        if (fin) begin
          next_m.cs_b = 1'b1; // RQ9
          next_m.mosi = 1'b0;
          next_m.busy = 1'b0;
          next_m.st   = dssp_pkg::M_IDLE;
        end
      end
    endcase
  end

  // single register for the master; select idles high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      m      <= '0;
      m.st   <= dssp_pkg::M_IDLE;
      m.cs_b <= 1'b1;
    end else begin
      m <= next_m;
    end
  end

  assign link.cs_b   = m.cs_b;
  assign link.sclk   = m.sclk;
  assign link.mosi   = m.mosi;
  assign busy        = m.busy;
  assign wdata_take  = m.wdata_take;
  assign rdata       = m.rdata;
  assign rdata_valid = m.rdata_valid;
  assign check_word  = m.check_word;
  assign check_valid = m.check_valid;

endmodule
`default_nettype wire

// File: test/dssp_link_properties.sv
/*
  Wire checks of the debug serial link between master and slave.
  Assumes both ends share sys_clk and the active-low rst_b.
*/
`default_nettype none
module dssp_link_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link wires
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        sclk_q;
  logic [11:0] rises;
  logic [1:0]  hi_rises;
  logic [23:0] hdr;
  logic [3:0]  fall_age;
  logic [15:0] chk;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // expected check word: command byte and address high byte
  assign chk = hdr[23:8];

  // frame counters: rises cleared while deselected, hi_rises while selected, so no frame leaks into the next
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      rises <= '0;
      hi_rises <= '0;
      hdr <= '0;
      fall_age <= '0;
    end else begin
      sclk_q <= sclk;
      if (sclk_q && !sclk) fall_age <= 4'h1;
      else if (fall_age != 4'hF) fall_age <= fall_age + 4'h1;
      if (cs_b) begin
        rises <= '0;
        if (sclk && !sclk_q && hi_rises != 2'h3) hi_rises <= hi_rises + 2'h1;
      end else begin
        hi_rises <= '0;
        if (sclk && !sclk_q) rises <= rises + 12'h001;
        if (sclk && !sclk_q && rises < 12'h018) hdr <= {hdr[22:0], mosi};
      end
    end
  end

  a_rearm_first: assert property (
    $fell(cs_b) |-> hi_rises >= 2'h2)
    else $error("select fell without two re-arm clocks");
  a_frame_words: assert property (
    $rose(cs_b) |-> rises[3:0] == 4'h8 && rises >= 12'h028)
    else $error("frame did not end on a whole word");
  a_sclk_half: assert property (
    $changed(sclk) && !cs_b |=> $stable(sclk) [*7])
    else $error("serial clock half period too short");
  a_mosi_settled: assert property (
    $rose(sclk) && !cs_b |-> $stable(mosi) [*5])
    else $error("data in moved around the clock rise");
  a_select_edges: assert property (
    $changed(cs_b) |-> !sclk)
    else $error("select moved while clock high");
  a_miso_after_fall: assert property (
    $changed(miso) && !cs_b |-> fall_age inside {[4'h2:4'h7]})
    else $error("data out moved away from a clock fall");
  a_check_word: assert property (
    $fell(sclk) && !cs_b && hdr[23:16] == dssp_pkg::CMD_READ
    && rises >= 12'h019 && rises <= 12'h028
    |-> miso == chk[4'(12'h028 - rises)])
    else $error("check word bit wrong");
  a_idle_out: assert property (
    $fell(sclk) && !cs_b && rises != 12'h000
    && (rises <= 12'h018 || hdr[23:16] != dssp_pkg::CMD_READ)
    |-> miso == dssp_pkg::MISO_SEL_IDLE)
    else $error("data out active outside a read");

  c_read: cover property ($rose(cs_b) && hdr[23:16] == dssp_pkg::CMD_READ);
  c_burst: cover property ($rose(cs_b) && rises >= 12'h038);
  c_rearm: cover property ($fell(cs_b) && hi_rises == 2'h2);
endmodule
`default_nettype wire

// File: test/debug_spi_slave_port_test.sv
/*
  Self-checking bench: master and slave joined by the link, a word memory
  behind the slave, requests made through the master's user side.
  Assumes a 50 MHz sys_clk and the codes of dssp_pkg.
*/
`default_nettype none
`define CHK(g, e) begin compares++; \
  if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); \
  end end
module debug_spi_slave_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 2;
  // user side of both ends
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  nwords = 8'h01;
  logic [15:0] wdata = 16'h0000;
  logic        cpu_stopped = 1'b0;
  logic        busy, wdata_take, rdata_valid, check_valid;
  logic [15:0] rdata, check_word, mem_addr, mem_wdata;
  logic [15:0] mem_rdata = 16'h0000;
  logic        mem_wr, mem_rd, sel_active, cmd_bad;
  // memory, write words and gathered read words
  logic [15:0] mem [0:65535];
  logic [15:0] wv [0:3];
  logic [15:0] rq [$];
  logic [15:0] ck;
  int          failures = 0;
  int          compares = 0;
  int          wr_cnt = 0;
  int          bad_cnt = 0;

  dssp_link_if dssp_link_if_i ();
  dssp_master dssp_master_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(dssp_link_if_i.master),
    .start(start), .cmd(cmd), .addr(addr), .nwords(nwords),
    .wdata(wdata), .busy(busy), .wdata_take(wdata_take), .rdata(rdata),
    .rdata_valid(rdata_valid), .check_word(check_word),
    .check_valid(check_valid));
  dssp_slave dssp_slave_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(dssp_link_if_i.slave),
    .cpu_stopped(cpu_stopped), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .sel_active(sel_active), .cmd_bad(cmd_bad));
  dssp_link_properties dssp_link_properties_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(dssp_link_if_i.cs_b),
    .sclk(dssp_link_if_i.sclk), .mosi(dssp_link_if_i.mosi),
    .miso(dssp_link_if_i.miso));

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // word memory, one-cycle read latency; counts writes and bad commands
  always @(posedge sys_clk) begin
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (mem_rd === 1'b1) mem_rdata <= #DLY mem[mem_addr];
    if (cmd_bad === 1'b1) bad_cnt <= bad_cnt + 1;
  end

  // one request; wv words stay up until taken, since the master
  // samples on the edge that raises its take pulse
  task automatic run(input logic [7:0] c, input logic [15:0] a,
                     input logic [7:0] n);
    int k;
    int wi;
    wi = 0;
    rq.delete();
    ck = 'x;
    cmd = c;
    addr = a;
    nwords = n;
    wdata = wv[0];
    start = 1'b1;
    @(posedge sys_clk);
    #DLY start = 1'b0;
    for (k = 0; k < 4000 && busy === 1'b1; k++) begin
      @(posedge sys_clk);
      #DLY;
      if (wdata_take === 1'b1 && wi < 3) begin
        wi++;
        wdata = wv[wi];
      end
      if (check_valid === 1'b1) ck = check_word;
      if (rdata_valid === 1'b1) rq.push_back(rdata);
    end
    if (k == 4000) failures++;
  endtask

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // cut a hang short: all frames need well under 8000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 16'(i) ^ 16'hA5A5;
    wv[0] = 16'h1111;
    wv[1] = 16'h2222;
    wv[2] = 16'h3333;
    wv[3] = 16'h4444;
    repeat (8) @(posedge sys_clk);
    #DLY rst_b = 1'b1;
    // write burst across a low-byte carry, neighbours untouched
    run(dssp_pkg::CMD_WRITE, 16'h12FE, 8'h03);
    `CHK(mem[16'h12FE], 16'h1111)
    `CHK(mem[16'h12FF], 16'h2222)
    `CHK(mem[16'h1300], 16'h3333)
    `CHK(mem[16'h12FD], 16'h12FD ^ 16'hA5A5)
    `CHK(mem[16'h1301], 16'h1301 ^ 16'hA5A5)
    `CHK(wr_cnt, 3)
    $display("write burst done");
    // read burst back to back, then a single untouched word
    run(dssp_pkg::CMD_READ, 16'h12FF, 8'h02);
    `CHK(ck, 16'h0312)
    `CHK(rq.size(), 2)
    `CHK(rq[0], 16'h2222)
    `CHK(rq[1], 16'h3333)
    run(dssp_pkg::CMD_READ, 16'h8000, 8'h01);
    `CHK(ck, 16'h0380)
    `CHK(rq.size(), 1)
    `CHK(rq[0], 16'h8000 ^ 16'hA5A5)
    $display("read tests done");
    // reset between frames: the port answers only after a fresh re-arm
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #DLY rst_b = 1'b1;
    // unknown command must not touch memory, even with new data
    wv[0] = 16'h5A5A;
    run(8'h5A, 16'h12FE, 8'h01);
    `CHK(bad_cnt, 1)
    `CHK(wr_cnt, 3)
    `CHK(mem[16'h12FE], 16'h1111)
    $display("unknown command done");
    // deselected output follows processor state
    cpu_stopped = 1'b1;
    repeat (4) @(posedge sys_clk);
    #DLY `CHK(dssp_link_if_i.miso, 1'b1)
    `CHK(sel_active, 1'b0)
    cpu_stopped = 1'b0;
    repeat (4) @(posedge sys_clk);
    #DLY `CHK(dssp_link_if_i.miso, 1'b0)
    $display("deselected output done");
    give_verdict();
  end
endmodule
`default_nettype wire
